// *** logic/qdac_device.sv ***
// Purpose: serial word receiver and channel latches of the quad converter
// Assumes: shifting runs on link_sclk; output side runs on ref_clk
// Notes:   analog stage is represented by code and enable outputs
module qdac_device (
  input  wire logic                                    ref_clk,
  input  wire logic                                    rst,
  qdac_link_if.device                                  link,
  output qdac_pkg::qdac_code_t [qdac_pkg::QDAC_NUM_CH-1:0] dac_code,
  output logic [qdac_pkg::QDAC_NUM_CH-1:0]             amp_enable,
  output logic                                         fast_settle,
  output logic                                         word_seen,
  output logic                                         early_end,
  output logic [15:0]                                  word_count
);
  import qdac_pkg::*;

  // link domain, shifting on falling edges
  logic [QDAC_WORD_BITS-1:0] shift_reg;
  logic [4:0]                bit_cnt_reg;
  logic [QDAC_WORD_BITS-1:0] word_reg;
  logic                      pend_tgl_reg;
  logic                      short_reg;
  logic [QDAC_WORD_BITS-1:0] shifted;

  // link domain, applying on rising edges
  logic                      apply_tgl_reg;
  qdac_code_t [QDAC_NUM_CH-1:0] in_code_reg;
  logic                      in_sleep_reg;
  logic                      in_fast_reg;
  logic                      in_short_reg;
  logic                      upd_tgl_reg;
  logic [QDAC_NUM_CH-1:0]    chan_hit;

  // reference domain
  logic [2:0]                upd_sync_reg;
  logic [1:0]                load_sync_reg;
  logic [1:0]                pd_sync_reg;
  logic                      upd_seen;
  qdac_code_t [QDAC_NUM_CH-1:0] shadow_code_reg;
  logic                      shadow_sleep_reg;
  logic                      shadow_fast_reg;
  qdac_code_t [QDAC_NUM_CH-1:0] dac_code_reg;
  logic                      dac_sleep_reg;
  logic                      dac_fast_reg;
  logic                      seen_reg;
  logic                      early_reg;
  logic [15:0]               wcount_reg;

  assign shifted = {shift_reg[QDAC_WORD_BITS-2:0], link.ser_data};

  // serial input: counter is rearmed by any falling edge with select low that
  // finds frame start high, so the host must give one such edge between words
  always_ff @(negedge link.link_sclk or posedge rst) begin
    if (rst) begin
      shift_reg    <= QDAC_WORD_RST;
      bit_cnt_reg  <= QDAC_CNT_ZERO;
      word_reg     <= QDAC_WORD_RST;
      pend_tgl_reg <= 1'b0;
      short_reg    <= 1'b0;
    end else if (!link.cs_n) begin
      if (link.frame_start) begin
        if (bit_cnt_reg != QDAC_CNT_ZERO && bit_cnt_reg < QDAC_CNT_FULL) begin
          // early frame end moves the partial contents as they stand
          word_reg     <= shift_reg;
          short_reg    <= 1'b1;
          pend_tgl_reg <= ~pend_tgl_reg;
        end
        bit_cnt_reg <= QDAC_CNT_ZERO;
      end else if (bit_cnt_reg < QDAC_CNT_FULL) begin
        shift_reg   <= shifted;
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == QDAC_CNT_LAST) begin
          word_reg     <= shifted;
          short_reg    <= 1'b0;
          pend_tgl_reg <= ~pend_tgl_reg;
        end
      end
    end
  end

  assign chan_hit = qdac_chan_hot(
    word_reg[QDAC_CHSEL_HI_POS:QDAC_CHSEL_LO_POS]);

  // apply on the first rising edge after the completing falling edge;
  // not gated by select so a select rise after this edge loses nothing
  always_ff @(posedge link.link_sclk or posedge rst) begin
    if (rst) begin
      apply_tgl_reg <= 1'b0;
      in_code_reg   <= '0;
      in_sleep_reg  <= 1'b0;
      in_fast_reg   <= 1'b0;
      in_short_reg  <= 1'b0;
      upd_tgl_reg   <= 1'b0;
    end else if (pend_tgl_reg != apply_tgl_reg) begin
      apply_tgl_reg <= pend_tgl_reg;
      for (int i = 0; i < QDAC_NUM_CH; i++) begin
        if (chan_hit[i]) begin
          in_code_reg[i] <= word_reg[QDAC_CODE_MSB:0];
        end
      end
      in_sleep_reg <= word_reg[QDAC_SLEEP_POS];
      in_fast_reg  <= word_reg[QDAC_FAST_POS];
      in_short_reg <= short_reg;
      upd_tgl_reg  <= ~upd_tgl_reg;
    end
  end

  // crossings into ref_clk: toggle for updates, two flops for pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upd_sync_reg <= 3'h0;
    end else begin
      upd_sync_reg <= {upd_sync_reg[1:0], upd_tgl_reg};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_sync_reg <= 2'h3;
      pd_sync_reg   <= 2'h0;
    end else begin
      load_sync_reg <= {load_sync_reg[0], link.output_load_n};
      pd_sync_reg   <= {pd_sync_reg[0], link.powerdown_pin_n};
    end
  end

  assign upd_seen = upd_sync_reg[2] ^ upd_sync_reg[1];

  // input latches are quiet for at least sixteen link clocks after a toggle,
  // far longer than the synchroniser delay, so the copy is safe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shadow_code_reg  <= '0;
      shadow_sleep_reg <= 1'b0;
      shadow_fast_reg  <= 1'b0;
    end else if (upd_seen) begin
      shadow_code_reg  <= in_code_reg;
      shadow_sleep_reg <= in_sleep_reg;
      shadow_fast_reg  <= in_fast_reg;
    end
  end

  // output latches follow the input latches only while load is low;
  // one process owns the whole array so it has a single driver
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < QDAC_NUM_CH; i++) begin
        dac_code_reg[i] <= QDAC_CODE_RST;
      end
    end else if (!load_sync_reg[1]) begin
      dac_code_reg <= shadow_code_reg;
    end
  end

  generate
    for (genvar ch = 0; ch < QDAC_NUM_CH; ch++) begin : g_dac
      // sleep bit or pin low disables every amplifier
      assign amp_enable[ch] = pd_sync_reg[1] & ~dac_sleep_reg;
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dac_sleep_reg <= 1'b0;
      dac_fast_reg  <= 1'b0;
    end else if (!load_sync_reg[1]) begin
      dac_sleep_reg <= shadow_sleep_reg;
      dac_fast_reg  <= shadow_fast_reg;
    end
  end

  // status toward the user side
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen_reg   <= 1'b0;
      early_reg  <= 1'b0;
      wcount_reg <= QDAC_WCNT_RST;
    end else begin
      seen_reg <= upd_seen;
      if (upd_seen) begin
        early_reg  <= in_short_reg;
        wcount_reg <= wcount_reg + 16'h0001;
      end
    end
  end

  // code is plain unsigned binary, full scale 4095
  assign dac_code    = dac_code_reg;
  // fast mode only while the power-down pin is high, so a part held down by the pin reports slow
  assign fast_settle = dac_fast_reg & pd_sync_reg[1];
  assign word_seen   = seen_reg;
  assign early_end   = early_reg;
  assign word_count  = wcount_reg;

endmodule : qdac_device

// *** logic/qdac_pkg.sv ***
// Purpose: shared constants and types for the quad converter serial link
// Assumes: host side runs on ref_clk at 125 MHz and divides it for the link
// Notes:   field positions follow the 16-bit control word layout
package qdac_pkg;

  localparam int QDAC_WORD_BITS = 16;
  localparam int QDAC_CODE_BITS = 12;
  localparam int QDAC_NUM_CH    = 4;

  // control word layout
  localparam int QDAC_CHSEL_HI_POS = 15;
  localparam int QDAC_CHSEL_LO_POS = 14;
  localparam int QDAC_SLEEP_POS    = 13;
  localparam int QDAC_FAST_POS     = 12;
  localparam int QDAC_CODE_MSB     = 11;

  localparam logic [4:0]  QDAC_CNT_FULL  = 5'h10;
  localparam logic [4:0]  QDAC_CNT_LAST  = 5'h0F;
  localparam logic [4:0]  QDAC_CNT_ZERO  = 5'h00;
  localparam logic [11:0] QDAC_CODE_RST  = 12'h000;
  localparam logic [15:0] QDAC_WORD_RST  = 16'h0000;
  localparam logic [15:0] QDAC_WCNT_RST  = 16'h0000;

  // timing: link clock is ref_clk divided down
  localparam int QDAC_REF_PERIOD_NS  = 8;
  localparam int QDAC_SCLK_PERIOD_NS = 64;
  localparam int QDAC_SCLK_HALF_CYC  =
    QDAC_SCLK_PERIOD_NS / (2 * QDAC_REF_PERIOD_NS);
  localparam int QDAC_LOAD_LOW_NS    = 64;
  localparam int QDAC_LOAD_LOW_CYC   =
    (QDAC_LOAD_LOW_NS + QDAC_REF_PERIOD_NS - 1) / QDAC_REF_PERIOD_NS;

  typedef logic [QDAC_CODE_BITS-1:0] qdac_code_t;

  typedef enum logic [1:0] {
    QDAC_CH_A = 2'b00,
    QDAC_CH_B = 2'b01,
    QDAC_CH_C = 2'b10,
    QDAC_CH_D = 2'b11
  } qdac_chan_e;

  // host sequencer, gray from idle through deselect; the return to idle flips two bits
  typedef enum logic [2:0] {
    QDAC_H_IDLE  = 3'b000,
    QDAC_H_SEL   = 3'b001,
    QDAC_H_SHIFT = 3'b011,
    QDAC_H_REARM = 3'b010,
    QDAC_H_DESEL = 3'b110
  } qdac_hstate_e;

  function automatic logic [QDAC_NUM_CH-1:0] qdac_chan_hot(
    input logic [1:0] sel
  );
    logic [QDAC_NUM_CH-1:0] hot;
    hot = '0;
    case (qdac_chan_e'(sel))
      QDAC_CH_A: hot = 4'h1;
      QDAC_CH_B: hot = 4'h2;
      QDAC_CH_C: hot = 4'h4;
      QDAC_CH_D: hot = 4'h8;
      default:   hot = 4'h0;
    endcase
    return hot;
  endfunction : qdac_chan_hot

endpackage : qdac_pkg

// *** logic/qdac_link_if.sv ***
// Purpose: serial link between host port and quad converter
// Assumes: all signals are driven by the host, none are two-way
// Notes:   link_sclk is the link clock made by the host
interface qdac_link_if;
  logic link_sclk;
  logic cs_n;
  logic frame_start;
  logic ser_data;
  logic output_load_n;
  logic powerdown_pin_n;

  modport host (
    output link_sclk,
    output cs_n,
    output frame_start,
    output ser_data,
    output output_load_n,
    output powerdown_pin_n
  );

  modport device (
    input link_sclk,
    input cs_n,
    input frame_start,
    input ser_data,
    input output_load_n,
    input powerdown_pin_n
  );
endinterface : qdac_link_if

// *** logic/qdac_host.sv ***
// Purpose: host serial port driving the quad converter link
// Assumes: ref_clk 125 MHz, link clock made here by a divider
// Notes:   one 16-bit word per frame, sent as two bytes back to back
module qdac_host (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  qdac_link_if.host         link,
  input  wire logic         word_valid,
  output logic              word_ready,
  input  wire logic [15:0]  word_data,
  input  wire logic         three_wire,
  input  wire logic         load_req,
  input  wire logic         pd_req,
  output logic              busy
);
  import qdac_pkg::*;

  localparam logic [2:0] HALF_LAST = 3'(QDAC_SCLK_HALF_CYC - 1);
  localparam logic [3:0] LOAD_CYC  = 4'(QDAC_LOAD_LOW_CYC);

  qdac_hstate_e              st_reg;
  logic [2:0]                div_reg;
  logic                      sclk_reg;
  logic                      rise_evt;
  logic                      cs_n_reg;
  logic                      fs_reg;
  logic [QDAC_WORD_BITS-1:0] sr_reg;
  logic [4:0]                sent_reg;
  logic [3:0]                load_cnt_reg;
  logic                      load_n_reg;
  logic                      pd_n_reg;

  // free-running divider so frame start high always meets a falling edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_reg  <= 3'h0;
      sclk_reg <= 1'b0;
    end else if (div_reg == HALF_LAST) begin
      div_reg  <= 3'h0;
      sclk_reg <= ~sclk_reg;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  assign rise_evt   = (div_reg == HALF_LAST) && !sclk_reg;
  assign word_ready = (st_reg == QDAC_H_IDLE) && rise_evt;
  assign busy       = (st_reg != QDAC_H_IDLE);

  // select, frame start and data change together with the rising link edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg   <= QDAC_H_IDLE;
      cs_n_reg <= 1'b1;
      fs_reg   <= 1'b1;
      sr_reg   <= QDAC_WORD_RST;
      sent_reg <= QDAC_CNT_ZERO;
    end else if (rise_evt) begin
      case (st_reg)
        QDAC_H_IDLE: begin
          // three-wire keeps select low, four-wire parks it high
          cs_n_reg <= ~three_wire;
          if (word_valid) begin
            sr_reg   <= word_data;
            cs_n_reg <= 1'b0;
            st_reg   <= QDAC_H_SEL;
          end
        end
        QDAC_H_SEL: begin
          fs_reg   <= 1'b0;
          sent_reg <= QDAC_CNT_ZERO;
          st_reg   <= QDAC_H_SHIFT;
        end
        QDAC_H_SHIFT: begin
          // high byte then low byte, no break at the byte seam
          sr_reg   <= {sr_reg[QDAC_WORD_BITS-2:0], 1'b0};
          sent_reg <= sent_reg + 5'h01;
          if (sent_reg == QDAC_CNT_LAST) begin
            fs_reg <= 1'b1;
            st_reg <= QDAC_H_REARM;
          end
        end
        QDAC_H_REARM: begin
          cs_n_reg <= ~three_wire;
          st_reg   <= QDAC_H_DESEL;
        end
        QDAC_H_DESEL: begin
          st_reg <= QDAC_H_IDLE;
        end
        default: begin
          st_reg <= QDAC_H_IDLE;
        end
      endcase
    end
  end

  // load pulse for simultaneous update of all channels
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_cnt_reg <= 4'h0;
      load_n_reg   <= 1'b1;
      pd_n_reg     <= 1'b1;
    end else begin
      pd_n_reg <= ~pd_req;
      if (load_req) begin
        load_cnt_reg <= LOAD_CYC;
        load_n_reg   <= 1'b0;
      end else if (load_cnt_reg > 4'h1) begin
        load_cnt_reg <= load_cnt_reg - 4'h1;
      end else begin
        load_cnt_reg <= 4'h0;
        load_n_reg   <= 1'b1;
      end
    end
  end

  assign link.link_sclk       = sclk_reg;
  assign link.cs_n            = cs_n_reg;
  assign link.frame_start     = fs_reg;
  assign link.ser_data        = sr_reg[QDAC_WORD_BITS-1];
  assign link.output_load_n   = load_n_reg;
  assign link.powerdown_pin_n = pd_n_reg;

endmodule : qdac_host

// *** sim/qdac_assertions.sv ***
// Purpose: timing checks on the converter serial link
// Assumes: every link signal is launched by the host on ref_clk
// Notes:   link clock half period is four ref_clk cycles
module qdac_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_sclk,
  input wire logic cs_n,
  input wire logic frame_start,
  input wire logic ser_data,
  input wire logic output_load_n,
  input wire logic powerdown_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] low_cnt;

  // cycles spent with frame start low, cleared while it is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 9'h000;
    end else if (frame_start) begin
      low_cnt <= 9'h000;
    end else begin
      low_cnt <= low_cnt + 9'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_CS_BEFORE_FS: assert property ($fell(frame_start) |-> !cs_n)
    else $error("frame start fell while deselected");
  AST_CS_IN_FRAME: assert property (!frame_start |-> !cs_n)
    else $error("select high inside a frame");
  AST_DATA_AT_RISE: assert property (
    $changed(ser_data) |-> $rose(link_sclk))
    else $error("data moved away from a rising link edge");
  AST_SCLK_HALF: assert property (
    $changed(link_sclk) |=> $stable(link_sclk)[*3])
    else $error("link clock half period not four cycles");
  AST_FRAME_LEN: assert property (
    $rose(frame_start) |-> low_cnt == 9'h080)
    else $error("frame not sixteen link periods long");
  AST_FS_GAP: assert property ($rose(frame_start) |-> frame_start[*8])
    else $error("frame start high too briefly");
  AST_CS_AFTER_FS: assert property ($rose(cs_n) |-> frame_start)
    else $error("select rose before frame start");
  AST_LOAD_PULSE: assert property (
    $fell(output_load_n) |-> !output_load_n[*8])
    else $error("load strobe low too briefly");

  cover property ($rose(frame_start));
  cover property ($fell(output_load_n));
  cover property ($fell(powerdown_pin_n));
endmodule : qdac_assertions

// *** sim/testbench.sv ***
// Purpose: host and converter ends joined, words sent and outputs checked
// Assumes: host holds the load strobe high except for its pulses
// Notes:   a bench monitor rebuilds each word from the wire
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import qdac_pkg::*;
  logic ref_clk, rst, word_valid, word_ready, three_wire, load_req;
  logic pd_req, busy, word_seen, early_end;
  logic [15:0] word_data, word_count, cap;
  qdac_code_t [QDAC_NUM_CH-1:0] dac_code;
  logic [QDAC_NUM_CH-1:0] amp_enable;
  logic fast_settle;
  int bad_count, checks, cyc, cap_n, n_exp, seen_n;
  logic [11:0] codes [4] = '{12'hFFF, 12'h800, 12'h7FF, 12'h001};

  qdac_link_if link_if ();
  qdac_host u_qdac_host (.ref_clk(ref_clk), .rst(rst), .link(link_if.host),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .three_wire(three_wire), .load_req(load_req), .pd_req(pd_req),
    .busy(busy));
  qdac_device u_qdac_device (.ref_clk(ref_clk), .rst(rst),
    .link(link_if.device), .dac_code(dac_code), .amp_enable(amp_enable),
    .fast_settle(fast_settle), .word_seen(word_seen), .early_end(early_end),
    .word_count(word_count));
  qdac_assertions u_chk (.ref_clk(ref_clk), .rst(rst),
    .link_sclk(link_if.link_sclk), .cs_n(link_if.cs_n),
    .frame_start(link_if.frame_start), .ser_data(link_if.ser_data),
    .output_load_n(link_if.output_load_n),
    .powerdown_pin_n(link_if.powerdown_pin_n));

  initial ref_clk = 1'b0;
  always #4 ref_clk = ~ref_clk;

  // rebuild the word as the device would see it
  always @(negedge link_if.frame_start) cap_n = 0;
  always @(negedge link_if.link_sclk) begin
    if (!link_if.cs_n && !link_if.frame_start) begin
      cap = {cap[14:0], link_if.ser_data};
      cap_n++;
    end
  end

  // count completion pulses from the device
  always @(posedge ref_clk) begin
    if (word_seen === 1'b1) begin
      seen_n++;
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // ceiling well above the roughly 1500 cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // called just after a rising edge; returns just after one
  task automatic send_word(input logic [15:0] w);
    word_data  <= w;
    word_valid <= 1'b1;
    @(negedge ref_clk);
    while (word_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    word_valid <= 1'b0;
    @(negedge ref_clk);
    while (busy !== 1'b0) @(negedge ref_clk);
    chk("wire word", w, cap);
    chk("wire bits", 16'h0010, 16'(cap_n));
    repeat (8) @(posedge ref_clk);
    n_exp++;
    chk("word count", 16'(n_exp), word_count);
    chk("seen pulses", 16'(n_exp), 16'(seen_n));
    chk("early end", 16'h0000, {15'h0, early_end});
  endtask : send_word

  task automatic pulse_load();
    load_req <= 1'b1;
    @(posedge ref_clk);
    load_req <= 1'b0;
    repeat (16) @(posedge ref_clk);
  endtask : pulse_load

  initial begin
    rst = 1'b1;
    word_valid = 1'b0;
    word_data = 16'h0000;
    three_wire = 1'b0;
    load_req = 1'b0;
    pd_req = 1'b0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      chk("reset code", 16'h0000, {4'h0, dac_code[i]});
    end
    chk("reset count", 16'h0000, word_count);
    $display("test reset finished");
    // every channel written while load is held off
    for (int i = 0; i < 4; i++) begin
      send_word({2'(i), 2'b01, codes[i]});
      chk("held code", 16'h0000, {4'h0, dac_code[i]});
    end
    pulse_load();
    for (int i = 0; i < 4; i++) begin
      chk("loaded code", {4'h0, codes[i]}, {4'h0, dac_code[i]});
    end
    chk("fast mode", 16'h0001, {15'h0, fast_settle});
    chk("amps on", 16'h000F, {12'h0, amp_enable});
    $display("test channel decode finished");
    // sleep bit, then slow mode
    send_word(16'h6123);
    pulse_load();
    chk("sleep amps", 16'h0000, {12'h0, amp_enable});
    chk("sleep code b", 16'h0123, {4'h0, dac_code[1]});
    send_word(16'h8456);
    pulse_load();
    chk("wake amps", 16'h000F, {12'h0, amp_enable});
    chk("slow mode", 16'h0000, {15'h0, fast_settle});
    chk("code c", 16'h0456, {4'h0, dac_code[2]});
    $display("test sleep and speed finished");
    // select stays low between words
    three_wire <= 1'b1;
    send_word(16'hD789);
    chk("select held", 16'h0000, {15'h0, link_if.cs_n});
    send_word(16'h1ABC);
    pulse_load();
    chk("code d", 16'h0789, {4'h0, dac_code[3]});
    chk("code a", 16'h0ABC, {4'h0, dac_code[0]});
    three_wire <= 1'b0;
    $display("test three wire finished");
    // hardware power down overrides the words
    pd_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("pin amps", 16'h0000, {12'h0, amp_enable});
    chk("pin speed", 16'h0000, {15'h0, fast_settle});
    pd_req <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("pin release", 16'h000F, {12'h0, amp_enable});
    $display("test power pin finished");
    complete_run();
  end
endmodule : testbench
